// File: include/fdc_regs.svh
// Register offsets, field positions, reset values and encodings of the FP dispatch block
`ifndef FDC_REGS_SVH
`define FDC_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define FDC_OFF_CTRL   8'h00
`define FDC_OFF_STAT   8'h04
`define FDC_OFF_MASK   8'h08
`define FDC_OFF_LINES  8'h0C

// ----------------------------------------------------------------
// Control register fields (control_reg_zero image)
// ----------------------------------------------------------------
`define FDC_CTRL_TRAP   0
`define FDC_CTRL_WMON   1
`define FDC_CTRL_NATIVE 2
`define FDC_CTRL_TSW    3
`define FDC_CTRL_CDIS   4
`define FDC_CTRL_NWT    5
`define FDC_CTRL_EMU   6
`define FDC_CTRL_W     7
`define FDC_CTRL_RST   7'h30

// ----------------------------------------------------------------
// Status and mask fields
// ----------------------------------------------------------------
`define FDC_STAT_FAULT 0
`define FDC_STAT_INT   1
`define FDC_STAT_HANG  2
`define FDC_STAT_EXT   3
`define FDC_STAT_W     4
`define FDC_STAT_RST   4'h0
`define FDC_MASK_RST   4'h0

// ----------------------------------------------------------------
// Model-specific and memory range type storage
// ----------------------------------------------------------------
`define FDC_MSR_NUM    8
`define FDC_MSR_IW     3
`define FDC_MSR_RST    32'h0000_0000
`define FDC_RANGE_NUM  4
`define FDC_TYPE_W     3
`define FDC_MT_UNCACHED 3'h0
`define FDC_MT_WT      3'h1
`define FDC_MT_WB      3'h2

// ----------------------------------------------------------------
// Internal cache lines
// ----------------------------------------------------------------
`define FDC_LINE_NUM   8
`define FDC_LINE_IW    3
`define FDC_LINE_RST   8'h00

`endif

// File: include/fdc_pkg.sv
// Types shared by the FP dispatch and cache init control block
package fdc_pkg;

  // Instruction classes presented by the core
  typedef enum logic [2:0] {
    INST_NONE,
    INST_FP,
    INST_SYNC,
    INST_RDSPEC,
    INST_WRSPEC
  } fdc_inst_t;

  // Dispatch state
  typedef enum logic {
    ST_RUN,
    ST_HUNG
  } fdc_state_t;

endpackage : fdc_pkg

// File: hdl/fdc_fp_gate.sv
// Decides whether an FP or sync instruction executes or faults
`timescale 1ns/10ps
module fdc_fp_gate #(
  parameter bit HAS_FPU = 1'b1
) (
  input  wire fdc_pkg::fdc_inst_t kind,
  input  wire logic               trapAll,
  input  wire logic               waitMon,
  input  wire logic               taskSw,
  input  wire logic               emuPresent,
  output logic        fault,
  output logic        execFpu,
  output logic        hang
);

  // Fault when trapping all, when no FPU exists, or sync with monitor and task switched
  always_comb begin
    fault   = 1'b0;
    execFpu = 1'b0;
    hang    = 1'b0;
    case (kind)
      fdc_pkg::INST_FP: begin
        fault   = trapAll || !HAS_FPU; // RQ1 RQ6
        execFpu = !fault;
        hang    = fault && trapAll && !emuPresent && !HAS_FPU; // RQ5
      end
      fdc_pkg::INST_SYNC: begin
        fault   = waitMon && taskSw; // RQ2 RQ3
        execFpu = !fault && HAS_FPU;
      end
      default: begin
        fault   = 1'b0;
      end
    endcase
  end

endmodule : fdc_fp_gate

// File: hdl/fdc_ctrl.sv
// FP dispatch, error routing, cache enable and range type control with APB registers
// Functional notes
// RQ1: Trap flag set faults FP, else FPU executes
// RQ2: Monitor clear: sync ignores task switched
// RQ3: Monitor and task switched: sync faults
// RQ4: Native flag picks internal or external error
// RQ5: Trap without FPU or emulator hangs
// RQ6: No-FPU variant faults every FP instruction; here one that hangs (RQ5) raises no fault
// RQ7: Software keeps trap flag matching FPU presence
// RQ8: Software sets monitor flag with integrated FPU
// RQ9: External controller systems clear native flag
// RQ10: Emulation: trap 1, monitor 0, native 1
// RQ11: Caches on only when both disables cleared
// RQ12: Reset sets both cache disable flags
// RQ13: All cache lines invalid after reset
// RQ14: Page bits control per-page caching
// RQ15: Range type registers select caching type
// RQ16: All-zero range type means uncached
// RQ17: Special-register instructions read and write model registers
// RQ18: Fault precedes any architectural state change
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "fdc_regs.svh"
module fdc_ctrl #(
  parameter bit HAS_FPU = 1'b1
) (
  input  wire logic               clock,
  input  wire logic               nrst,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic                    irq,
  // Instruction issue from the core
  input  wire logic               instValid,
  input  wire fdc_pkg::fdc_inst_t instKind,
  input  wire logic [2:0]         instIndex,
  input  wire logic [31:0]        instData,
  output logic                    instDone,
  output logic                    instFault,
  output logic                    fpuIssue,
  output logic [31:0]             instRdData,
  output logic                    hangOut,
  // Unmasked FP exception from the FPU
  input  wire logic               fpuErr,
  output logic                    fpErrInt,
  output logic                    fpErrExt,
  // Memory access classification
  input  wire logic               memReq,
  input  wire logic [31:0]        memAddr,
  input  wire logic               memPageCacheOff,
  input  wire logic               memPageWriteThru,
  input  wire logic               lineFill,
  input  wire logic [2:0]         lineIdx,
  output logic                    memAck,
  output logic                    memCacheable,
  output logic                    memWriteThru,
  output logic                    cacheEnable
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rstMeta_reg;
  logic rstn;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstMeta_reg <= 1'b0;
      rstn        <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstn        <= rstMeta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Register file and APB slave
  // ----------------------------------------------------------------
  logic [`FDC_CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [`FDC_STAT_W-1:0] stat_reg, stat_next;
  logic [`FDC_STAT_W-1:0] mask_reg, mask_next;
  logic [`FDC_STAT_W-1:0] events;
  logic [31:0]            prdata_reg, prdata_next;
  logic                   pready_reg, pready_next;
  logic                   pslverr_reg, pslverr_next;
  logic                   irq_reg, irq_next;
  logic [`FDC_LINE_NUM-1:0] lineValid_reg, lineValid_next;
  logic                   wrAcc;

  // True for an aligned offset that holds a register
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == `FDC_OFF_CTRL) || (a == `FDC_OFF_STAT) ||
               (a == `FDC_OFF_MASK) || (a == `FDC_OFF_LINES);
  endfunction : isMapped

  assign wrAcc = psel && penable && pready_reg && pwrite && isMapped(paddr);

  // Next register values, read data and the one-wait-free answer
  always_comb begin
    ctrl_next    = ctrl_reg;
    mask_next    = mask_reg;
    stat_next    = stat_reg;
    prdata_next  = prdata_reg;
    pready_next  = psel && !penable;
    pslverr_next = psel && !penable && !isMapped(paddr);
    if (wrAcc && paddr == `FDC_OFF_CTRL) begin
      ctrl_next = pwdata[`FDC_CTRL_W-1:0];
    end
    if (wrAcc && paddr == `FDC_OFF_MASK) begin
      mask_next = pwdata[`FDC_STAT_W-1:0];
    end
    if (wrAcc && paddr == `FDC_OFF_STAT) begin
      stat_next = stat_reg & ~pwdata[`FDC_STAT_W-1:0];
    end
    stat_next = stat_next | events; // Set wins over clear
    if (psel && !penable) begin
      case (paddr)
        `FDC_OFF_CTRL:  prdata_next = {{(32-`FDC_CTRL_W){1'b0}}, ctrl_reg};
        `FDC_OFF_STAT:  prdata_next = {{(32-`FDC_STAT_W){1'b0}}, stat_reg};
        `FDC_OFF_MASK:  prdata_next = {{(32-`FDC_STAT_W){1'b0}}, mask_reg};
        `FDC_OFF_LINES: prdata_next = {{(32-`FDC_LINE_NUM){1'b0}}, lineValid_reg};
        default:        prdata_next = 32'h0000_0000;
      endcase
    end
    irq_next = |(stat_next & mask_next);
  end

  // Register file flops; cache disables start set
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg    <= `FDC_CTRL_RST; // RQ12
      stat_reg    <= `FDC_STAT_RST;
      mask_reg    <= `FDC_MASK_RST;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      stat_reg    <= stat_next;
      mask_reg    <= mask_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      irq_reg     <= irq_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq     = irq_reg;

  // ----------------------------------------------------------------
  // Instruction dispatch and model-specific registers
  // ----------------------------------------------------------------
  fdc_pkg::fdc_state_t state_reg, state_next;
  logic [31:0] msr_reg [`FDC_MSR_NUM];
  logic [31:0] msr_next [`FDC_MSR_NUM];
  logic        done_reg, done_next;
  logic        fault_reg, fault_next;
  logic        issue_reg, issue_next;
  logic [31:0] rdData_reg, rdData_next;
  logic        errInt_reg, errInt_next;
  logic        errExt_reg, errExt_next;
  logic        gateFault, gateExec, gateHang;
  logic        take;

  fdc_fp_gate #(
    .HAS_FPU    (HAS_FPU)
  ) u_gate (
    .kind       (instKind),
    .trapAll    (ctrl_reg[`FDC_CTRL_TRAP]),
    .waitMon    (ctrl_reg[`FDC_CTRL_WMON]),
    .taskSw     (ctrl_reg[`FDC_CTRL_TSW]),
    .emuPresent (ctrl_reg[`FDC_CTRL_EMU]),
    .fault      (gateFault),
    .execFpu    (gateExec),
    .hang       (gateHang)
  );

  assign take = instValid && (state_reg == fdc_pkg::ST_RUN);

  // Dispatch decision; a fault suppresses the FPU issue and, unless it hangs, still sets done and the fault status
  always_comb begin
    state_next  = state_reg;
    msr_next    = msr_reg;
    done_next   = take;
    fault_next  = take && gateFault; // RQ18
    issue_next  = take && gateExec; // RQ1
    rdData_next = rdData_reg;
    errInt_next = fpuErr && (state_reg == fdc_pkg::ST_RUN) && ctrl_reg[`FDC_CTRL_NATIVE]; // RQ4
    errExt_next = fpuErr && (state_reg == fdc_pkg::ST_RUN) && !ctrl_reg[`FDC_CTRL_NATIVE]; // RQ4
    case (state_reg)
      fdc_pkg::ST_RUN: begin
        if (take && gateHang) begin
          state_next = fdc_pkg::ST_HUNG; // RQ5
          done_next  = 1'b0;
          fault_next = 1'b0;
        end else if (take && instKind == fdc_pkg::INST_RDSPEC) begin
          rdData_next = msr_reg[instIndex]; // RQ17
        end else if (take && instKind == fdc_pkg::INST_WRSPEC) begin
          msr_next[instIndex] = instData; // RQ17
        end
      end
      fdc_pkg::ST_HUNG: begin
        done_next = 1'b0;
      end
      default: begin
        state_next = fdc_pkg::ST_RUN;
      end
    endcase
    events = '0;
    events[`FDC_STAT_FAULT] = fault_next;
    events[`FDC_STAT_INT]  = errInt_next;
    events[`FDC_STAT_EXT]  = errExt_next;
    events[`FDC_STAT_HANG] = (state_next == fdc_pkg::ST_HUNG) &&
                             (state_reg == fdc_pkg::ST_RUN);
  end

  // Dispatch flops; range types clear to uncached at reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg  <= fdc_pkg::ST_RUN;
      msr_reg    <= '{default: `FDC_MSR_RST}; // RQ16
      done_reg   <= 1'b0;
      fault_reg  <= 1'b0;
      issue_reg  <= 1'b0;
      rdData_reg <= 32'h0000_0000;
      errInt_reg <= 1'b0;
      errExt_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      msr_reg    <= msr_next;
      done_reg   <= done_next;
      fault_reg  <= fault_next;
      issue_reg  <= issue_next;
      rdData_reg <= rdData_next;
      errInt_reg <= errInt_next;
      errExt_reg <= errExt_next;
    end
  end

  assign instDone   = done_reg;
  assign instFault  = fault_reg;
  assign fpuIssue   = issue_reg;
  assign instRdData = rdData_reg;
  assign hangOut    = (state_reg == fdc_pkg::ST_HUNG);
  assign fpErrInt   = errInt_reg;
  assign fpErrExt   = errExt_reg;

  // ----------------------------------------------------------------
  // Memory access classification and cache lines
  // ----------------------------------------------------------------
  logic                  ack_reg, ack_next;
  logic                  cach_reg, cach_next;
  logic                  wt_reg, wt_next;
  logic                  cen_reg, cen_next;
  logic [`FDC_TYPE_W-1:0] rangeType;

  // Range entries 0..3 each cover one quarter of the physical space
  assign rangeType = msr_reg[{1'b0, memAddr[31:30]}][`FDC_TYPE_W-1:0]; // RQ15

  // Cacheable only when enabled, page allows it and the range is not uncached
  always_comb begin
    cen_next  = !ctrl_reg[`FDC_CTRL_CDIS] && !ctrl_reg[`FDC_CTRL_NWT]; // RQ11
    ack_next  = memReq;
    cach_reg_hold: begin
      cach_next = cach_reg;
      wt_next   = wt_reg;
    end
    if (memReq) begin
      cach_next = cen_reg && !memPageCacheOff && (rangeType != `FDC_MT_UNCACHED); // RQ14 RQ16
      wt_next   = memPageWriteThru || (rangeType == `FDC_MT_WT); // RQ14
    end
    lineValid_next = lineValid_reg;
    if (lineFill && cen_reg) begin
      lineValid_next[lineIdx] = 1'b1;
    end
  end

  // Classification flops; every line starts invalid
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_reg       <= 1'b0;
      cach_reg      <= 1'b0;
      wt_reg        <= 1'b0;
      cen_reg       <= 1'b0;
      lineValid_reg <= `FDC_LINE_RST; // RQ13
    end else begin
      ack_reg       <= ack_next;
      cach_reg      <= cach_next;
      wt_reg        <= wt_next;
      cen_reg       <= cen_next;
      lineValid_reg <= lineValid_next;
    end
  end

  assign memAck       = ack_reg;
  assign memCacheable = cach_reg;
  assign memWriteThru = wt_reg;
  assign cacheEnable  = cen_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_trap_fault;
    @(posedge clock) disable iff (!rstn)
    take && instKind == fdc_pkg::INST_FP && ctrl_reg[`FDC_CTRL_TRAP] && !gateHang
      |=> instFault && !fpuIssue;
  endproperty
  a_trap_fault: assert property (p_trap_fault) else $error("FP not trapped"); // RQ1

  property p_fpu_exec;
    @(posedge clock) disable iff (!rstn)
    take && instKind == fdc_pkg::INST_FP && !ctrl_reg[`FDC_CTRL_TRAP] && HAS_FPU
      |=> fpuIssue && !instFault;
  endproperty
  a_fpu_exec: assert property (p_fpu_exec) else $error("FP not executed"); // RQ1

  property p_sync_ignore;
    @(posedge clock) disable iff (!rstn)
    take && instKind == fdc_pkg::INST_SYNC && !ctrl_reg[`FDC_CTRL_WMON] |=> !instFault;
  endproperty
  a_sync_ignore: assert property (p_sync_ignore) else $error("Sync faulted"); // RQ2

  property p_sync_trap;
    @(posedge clock) disable iff (!rstn)
    take && instKind == fdc_pkg::INST_SYNC && ctrl_reg[`FDC_CTRL_WMON] &&
      ctrl_reg[`FDC_CTRL_TSW] |=> instFault && stat_reg[`FDC_STAT_FAULT];
  endproperty
  a_sync_trap: assert property (p_sync_trap) else $error("Sync not trapped"); // RQ3

  property p_err_route;
    @(posedge clock) disable iff (!rstn)
    fpuErr && !hangOut |=> (fpErrInt == $past(ctrl_reg[`FDC_CTRL_NATIVE])) &&
      (fpErrExt != fpErrInt);
  endproperty
  a_err_route: assert property (p_err_route) else $error("FP error misrouted"); // RQ4

  property p_hang;
    @(posedge clock) disable iff (!rstn)
    take && gateHang |=> hangOut [*3];
  endproperty
  a_hang: assert property (p_hang) else $error("Did not hang"); // RQ5

  property p_no_fpu;
    @(posedge clock) disable iff (!rstn)
    !HAS_FPU && take && instKind == fdc_pkg::INST_FP |=> !fpuIssue;
  endproperty
  a_no_fpu: assert property (p_no_fpu) else $error("FP issued without FPU"); // RQ6

  property p_cache_on;
    @(posedge clock) disable iff (!rstn)
    memAck && memCacheable |-> $past(cen_reg) && !$past(memPageCacheOff);
  endproperty
  a_cache_on: assert property (p_cache_on) else $error("Cached while disabled"); // RQ11 RQ14

  property p_reset_vals;
    @(posedge clock) disable iff (!nrst)
    $rose(rstn) |-> ctrl_reg[`FDC_CTRL_CDIS] && ctrl_reg[`FDC_CTRL_NWT] && lineValid_reg == '0;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("Bad reset state"); // RQ12 RQ13

  property p_zero_type;
    @(posedge clock) disable iff (!rstn)
    memReq && rangeType == `FDC_MT_UNCACHED |=> !memCacheable;
  endproperty
  a_zero_type: assert property (p_zero_type) else $error("Zero type cached"); // RQ16

  property p_msr_read;
    @(posedge clock) disable iff (!rstn)
    take && instKind == fdc_pkg::INST_RDSPEC |=> instDone &&
      instRdData == $past(msr_reg[instIndex]);
  endproperty
  a_msr_read: assert property (p_msr_read) else $error("MSR read wrong"); // RQ17

  property p_fault_first;
    @(posedge clock) disable iff (!rstn)
    instFault |-> !fpuIssue && $stable(msr_reg[0]);
  endproperty
  a_fault_first: assert property (p_fault_first) else $error("State changed on fault"); // RQ18

endmodule : fdc_ctrl

// File: hdl/fdc_spare_unused.sv
// Holds no logic
`timescale 1ns/10ps

// File: sim/fdc_ctrl_tb.sv
// Self-checking bench for the FP dispatch and cache init control block
`timescale 1ns/10ps
`include "fdc_regs.svh"
module fdc_ctrl_tb;
  logic               clock, nrst, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, instData, instRdData, memAddr;
  logic               instValid, instDone, instFault, fpuIssue, hangOut;
  fdc_pkg::fdc_inst_t instKind;
  logic [2:0]         instIndex, lineIdx;
  logic               fpuErr, fpErrInt, fpErrExt, memReq, memPageCacheOff, memPageWriteThru;
  logic               lineFill, memAck, memCacheable, memWriteThru, cacheEnable;
  int                 errors, checksDone;

  fdc_ctrl #(.HAS_FPU(1'h1)) fdc_ctrl_inst (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .instValid(instValid), .instKind(instKind), .instIndex(instIndex),
    .instData(instData), .instDone(instDone), .instFault(instFault), .fpuIssue(fpuIssue),
    .instRdData(instRdData), .hangOut(hangOut), .fpuErr(fpuErr), .fpErrInt(fpErrInt),
    .fpErrExt(fpErrExt), .memReq(memReq), .memAddr(memAddr),
    .memPageCacheOff(memPageCacheOff), .memPageWriteThru(memPageWriteThru),
    .lineFill(lineFill), .lineIdx(lineIdx), .memAck(memAck), .memCacheable(memCacheable),
    .memWriteThru(memWriteThru), .cacheEnable(cacheEnable)
  );

  logic               done2, fault2, issue2, hang2;
  // No-FPU variant on the same stimulus; only its dispatch outputs are watched
  fdc_ctrl #(.HAS_FPU(1'h0)) fdc_ctrl_nofpu_inst (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .irq(),
    .instValid(instValid), .instKind(instKind), .instIndex(instIndex), .instData(instData),
    .instDone(done2), .instFault(fault2), .fpuIssue(issue2), .instRdData(), .hangOut(hang2),
    .fpuErr(fpuErr), .fpErrInt(), .fpErrExt(), .memReq(memReq), .memAddr(memAddr),
    .memPageCacheOff(memPageCacheOff), .memPageWriteThru(memPageWriteThru),
    .lineFill(lineFill), .lineIdx(lineIdx), .memAck(), .memCacheable(), .memWriteThru(),
    .cacheEnable()
  );

  // ----------------------------------------------------------------
  // Clock and report
  // ----------------------------------------------------------------
  // 25 MHz clock
  always #20 clock = ~clock;

  task automatic tally_and_finish();
    if (errors == 0 && checksDone > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp1(input string nm, input logic exp, input logic got);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask : cmp1

  task automatic cmp32(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp32

  // ----------------------------------------------------------------
  // APB master: setup, access held until pready is seen at an edge
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clock);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      errors++;
      tally_and_finish();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
    logic [31:0] d;
    logic        e;
    apb(1'h0, a, 32'h0000_0000, d, e);
    cmp32("prdata", exp, d);
    cmp1("pslverr", expErr, e);
  endtask : rdChk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'h1, a, v, d, e);
    cmp1("pslverr", 1'h0, e);
  endtask : wr

  // ----------------------------------------------------------------
  // Core side: one-cycle requests, answer looked at one cycle later
  // ----------------------------------------------------------------
  task automatic issue(input fdc_pkg::fdc_inst_t k, input logic [2:0] ix, input logic [31:0] d);
    @(posedge clock);
    instValid <= 1'h1;
    instKind  <= k;
    instIndex <= ix;
    instData  <= d;
    @(posedge clock);
    instValid <= 1'h0;
    @(negedge clock);
  endtask : issue

  task automatic instChk(input logic expFault);
    cmp1("instDone", 1'h1, instDone);
    cmp1("instFault", expFault, instFault);
    cmp1("fpuIssue", ~expFault, fpuIssue);
    cmp1("hangOut", 1'h0, hangOut);
  endtask : instChk

  task automatic memChk(input logic [31:0] a, input logic pco, input logic page_write_through_bit,
                        input logic expC, input logic expW);
    @(posedge clock);
    memReq           <= 1'h1;
    memAddr          <= a;
    memPageCacheOff  <= pco;
    memPageWriteThru <= page_write_through_bit;
    @(posedge clock);
    memReq <= 1'h0;
    @(negedge clock);
    cmp1("memAck", 1'h1, memAck);
    cmp1("memCacheable", expC, memCacheable);
    cmp1("memWriteThru", expW, memWriteThru);
  endtask : memChk

  task automatic doReset();
    @(posedge clock);
    nrst <= 1'h0;
    repeat (12) @(posedge clock);
    nrst <= 1'h1;
    repeat (2) @(posedge clock);
  endtask : doReset

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'h0;
    nrst = 1'h0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {instValid, instIndex, instData, fpuErr, memReq, memAddr} = '0;
    {memPageCacheOff, memPageWriteThru, lineFill, lineIdx} = '0;
    instKind = fdc_pkg::INST_NONE;
    errors = 0;
    checksDone = 0;
    doReset();
    // Reset state and an unmapped offset
    rdChk(`FDC_OFF_CTRL, 32'h0000_0030, 1'h0);
    rdChk(`FDC_OFF_LINES, 32'h0000_0000, 1'h0);
    rdChk(`FDC_OFF_STAT, 32'h0000_0000, 1'h0);
    rdChk(`FDC_OFF_MASK, 32'h0000_0000, 1'h0);
    rdChk(8'h10, 32'h0000_0000, 1'h1);
    cmp1("cacheEnable", 1'h0, cacheEnable);
    // Caches on only with both disable flags clear, ends enabled
    for (int i = 3; i >= 0; i--) begin
      wr(`FDC_OFF_CTRL, 32'(i) << 4);
      repeat (2) @(negedge clock);
      cmp1("cacheEnable", i == 0, cacheEnable);
    end
    // Trap flag selects FPU execution or fault; the no-FPU variant faults, then hangs
    issue(fdc_pkg::INST_FP, 3'h0, 32'h0000_0000);
    instChk(1'h0);
    cmp1("instFault2", 1'h1, fault2);
    cmp1("fpuIssue2", 1'h0, issue2);
    wr(`FDC_OFF_CTRL, 32'h0000_0001);
    issue(fdc_pkg::INST_FP, 3'h0, 32'h0000_0000);
    instChk(1'h1);
    cmp1("hangOut2", 1'h1, hang2);
    cmp1("instDone2", 1'h0, done2);
    // Fault status, mask and level interrupt
    rdChk(`FDC_OFF_STAT, 32'h0000_0001, 1'h0);
    cmp1("irq", 1'h0, irq);
    wr(`FDC_OFF_MASK, 32'h0000_0001);
    repeat (2) @(negedge clock);
    cmp1("irq", 1'h1, irq);
    wr(`FDC_OFF_STAT, 32'h0000_0001);
    repeat (2) @(negedge clock);
    cmp1("irq", 1'h0, irq);
    rdChk(`FDC_OFF_STAT, 32'h0000_0000, 1'h0);
    // Sync instruction against monitor and task-switched flags
    for (int i = 0; i < 4; i++) begin
      wr(`FDC_OFF_CTRL, (32'(i[1]) << 3) | (32'(i[0]) << 1));
      issue(fdc_pkg::INST_SYNC, 3'h0, 32'h0000_0000);
      instChk(i == 3);
    end
    // Emulation setting with task switched: FP traps, sync runs
    wr(`FDC_OFF_CTRL, 32'h0000_000D);
    issue(fdc_pkg::INST_FP, 3'h0, 32'h0000_0000);
    instChk(1'h1);
    issue(fdc_pkg::INST_SYNC, 3'h0, 32'h0000_0000);
    instChk(1'h0);
    // Unmasked FP error routed internally or externally
    for (int ne = 0; ne < 2; ne++) begin
      wr(`FDC_OFF_CTRL, 32'(ne) << 2);
      @(posedge clock);
      fpuErr <= 1'h1;
      @(posedge clock);
      fpuErr <= 1'h0;
      @(negedge clock);
      cmp1("fpErrInt", ne == 1, fpErrInt);
      cmp1("fpErrExt", ne == 0, fpErrExt);
    end
    rdChk(`FDC_OFF_STAT, 32'h0000_000B, 1'h0);
    wr(`FDC_OFF_STAT, 32'h0000_000F);
    // Special registers and range types, caching enabled, then disabled
    issue(fdc_pkg::INST_WRSPEC, 3'h0, 32'h0000_0002);
    issue(fdc_pkg::INST_RDSPEC, 3'h0, 32'h0000_0000);
    cmp32("instRdData", 32'h0000_0002, instRdData);
    issue(fdc_pkg::INST_RDSPEC, 3'h1, 32'h0000_0000);
    cmp32("instRdData", 32'h0000_0000, instRdData);
    memChk(32'h4000_0000, 1'h0, 1'h0, 1'h0, 1'h0);
    memChk(32'h0000_0000, 1'h0, 1'h0, 1'h1, 1'h0);
    memChk(32'h0000_0000, 1'h1, 1'h0, 1'h0, 1'h0);
    memChk(32'h0000_0000, 1'h0, 1'h1, 1'h1, 1'h1);
    issue(fdc_pkg::INST_WRSPEC, 3'h0, 32'h0000_0001);
    memChk(32'h0000_0000, 1'h0, 1'h0, 1'h1, 1'h1);
    wr(`FDC_OFF_CTRL, 32'h0000_0010);
    memChk(32'h0000_0000, 1'h0, 1'h0, 1'h0, 1'h1);
    // Line fill while enabled, then a second reset invalidates it
    wr(`FDC_OFF_CTRL, 32'h0000_0000);
    @(posedge clock);
    lineFill <= 1'h1;
    lineIdx  <= 3'h3;
    @(posedge clock);
    lineFill <= 1'h0;
    rdChk(`FDC_OFF_LINES, 32'h0000_0008, 1'h0);
    doReset();
    rdChk(`FDC_OFF_LINES, 32'h0000_0000, 1'h0);
    rdChk(`FDC_OFF_CTRL, 32'h0000_0030, 1'h0);
    cmp1("hangOut2", 1'h0, hang2);
    issue(fdc_pkg::INST_RDSPEC, 3'h0, 32'h0000_0000);
    cmp32("instRdData", 32'h0000_0000, instRdData);
    tally_and_finish();
  end
endmodule : fdc_ctrl_tb
